// >>> hdl/dsbr_pkg.sv
// constants and types shared by the debug status, breakpoint and forced reset block
package dsbr_pkg;
   // ----------------------------------------------------------------------
   // status, control and forced reset register field positions
   // ----------------------------------------------------------------------
   localparam int unsigned DATA_VALID_FAILURE_BIT = 0;
   localparam int unsigned WAIT_STOP_FAILURE_BIT = 1;
   localparam int unsigned WAIT_STOP_STATUS_BIT = 2;
   localparam int unsigned FORCE_TAG_SELECT_BIT = 4;
   localparam int unsigned BREAKPOINT_ENABLE_BIT = 5;
   localparam int unsigned DEBUG_ACTIVE_FLAG_BIT = 6;
   localparam int unsigned FORCED_RESET_BIT = 0;

   // ----------------------------------------------------------------------
   // reset and read-back values
   // ----------------------------------------------------------------------
   localparam logic [15:0] BKPT_RESET = 16'h0000;
   localparam logic [7:0] FORCED_RESET_READ = 8'h00;
   localparam logic RESET_PULSE_CYCLES_INIT = 1'b1;

   // ----------------------------------------------------------------------
   // serial debug command kinds presented by the command decoder
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      DSBR_CMD_NONE,
      DSBR_CMD_READ_STATUS,
      DSBR_CMD_WRITE_CONTROL,
      DSBR_CMD_BKPT_READ,
      DSBR_CMD_BKPT_WRITE,
      DSBR_CMD_FRST_READ,
      DSBR_CMD_FRST_WRITE,
      DSBR_CMD_HALT
   } dsbr_cmd_t;
endpackage

// >>> hdl/dsbr_bkpt_if.sv
// breakpoint setup carried from the register file to the comparator
`timescale 1ns/1ps
interface dsbr_bkpt_if;
   logic enable;
   logic force_sel;
   logic [15:0] match_addr;
   modport regs (output enable, output force_sel, output match_addr);
   modport cmp (input enable, input force_sel, input match_addr);
endinterface

// >>> hdl/dsbr_bkpt_cmp.sv
// breakpoint address comparator
`timescale 1ns/1ps
module dsbr_bkpt_cmp (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // setup
   dsbr_bkpt_if.cmp cfg,
   // cpu address bus
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_addr_valid_i,
   // requests
   output logic force_req_o,
   output logic tag_req_o
);
   logic hit;

   assign hit = cfg.enable && cpu_addr_valid_i && (cpu_addr_i == cfg.match_addr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_req_o <= 1'b0;
         tag_req_o <= 1'b0;
      end else begin
         force_req_o <= hit && cfg.force_sel;
         tag_req_o <= hit && !cfg.force_sel;
      end
   end
endmodule

// >>> hdl/dsbr_top.sv
// debug status bits, breakpoint match register and forced reset register
`timescale 1ns/1ps
// Notes on behaviour
// - wait/stop status reads 1 in wait/stop, or after halt left wait/stop.
// - wait/stop status reads 0 while running or debug entered from running.
// - in wait/stop only the halt command is executed; others are ignored.
// - halt during wait/stop wakes the cpu into active debug mode.
// - wait/stop failure set when memory access clashes with wait/stop entry.
// - data valid failure flags access failed on unfinished slow access.
// - 16-bit breakpoint match address, governed by enable and force/tag bits.
// - breakpoint register reached only by dedicated serial commands.
// - forced reset register accepts only serial debug writes.
// - forced reset register always reads zero.
// - writing 1 to the forced reset bit produces a full device reset.
// - debug-active flag reads 1 in active debug mode, 0 when running.
// - breakpoint enable clear, its reset value, requests no breakpoints.
// - force select forces debug mode at boundary; otherwise opcode is tagged.
module dsbr_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // serial debug command port
   input wire dsbr_pkg::dsbr_cmd_t cmd_i,
   input wire logic [15:0] cmd_wdata_i,
   output logic [15:0] cmd_rdata_o,
   output logic cmd_done_o,
   // user program write attempt to forced reset register
   input wire logic cpu_frst_write_i,
   input wire logic [7:0] cpu_frst_wdata_i,
   // cpu state
   input wire logic cpu_wait_stop_i,
   input wire logic cpu_debug_active_i,
   input wire logic cpu_mem_ws_conflict_i,
   input wire logic cpu_mem_slow_conflict_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_addr_valid_i,
   // requests to the cpu and system
   output logic halt_req_o,
   output logic bkpt_force_o,
   output logic bkpt_tag_o,
   output logic sys_reset_o
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic ws_q;
   logic wsf_q;
   logic dvf_q;
   logic bken_q;
   logic fts_q;
   logic [15:0] bkpt_q;
   logic woke_q;
   logic [7:0] status;
   dsbr_pkg::dsbr_cmd_t cmd_eff;
   logic do_any;
   logic do_halt;
   logic do_write_control;
   logic do_bkpt_write;
   logic do_frst_write;
   dsbr_bkpt_if bk ();

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // command as it takes effect; a sleeping cpu only honours halt
   function automatic dsbr_pkg::dsbr_cmd_t gate_cmd(input dsbr_pkg::dsbr_cmd_t k,
         input logic sleeping);
      if (sleeping && k != dsbr_pkg::DSBR_CMD_HALT) begin
         return dsbr_pkg::DSBR_CMD_NONE;
      end else begin
         return k;
      end
   endfunction

   // sticky failure flag; an event in the clearing cycle wins
   function automatic logic flag_next(input logic q, input logic set, input logic clr);
      if (set) begin
         return 1'b1;
      end else if (clr) begin
         return 1'b0;
      end else begin
         return q;
      end
   endfunction

   // ----------------------------------------------------------------------
   // command decoding
   // ----------------------------------------------------------------------
   assign cmd_eff = gate_cmd(cmd_i, cpu_wait_stop_i);
   assign do_any = (cmd_eff != dsbr_pkg::DSBR_CMD_NONE);
   assign do_halt = (cmd_eff == dsbr_pkg::DSBR_CMD_HALT);
   assign do_write_control = (cmd_eff == dsbr_pkg::DSBR_CMD_WRITE_CONTROL);
   assign do_bkpt_write = (cmd_eff == dsbr_pkg::DSBR_CMD_BKPT_WRITE);
   assign do_frst_write = (cmd_eff == dsbr_pkg::DSBR_CMD_FRST_WRITE);

   // ----------------------------------------------------------------------
   // status byte
   // ----------------------------------------------------------------------
   always_comb begin
      status = 8'h00;
      status[dsbr_pkg::DEBUG_ACTIVE_FLAG_BIT] = cpu_debug_active_i;
      status[dsbr_pkg::BREAKPOINT_ENABLE_BIT] = bken_q;
      status[dsbr_pkg::FORCE_TAG_SELECT_BIT] = fts_q;
      status[dsbr_pkg::WAIT_STOP_STATUS_BIT] = ws_q;
      status[dsbr_pkg::WAIT_STOP_FAILURE_BIT] = wsf_q;
      status[dsbr_pkg::DATA_VALID_FAILURE_BIT] = dvf_q;
   end

   // ----------------------------------------------------------------------
   // wait/stop status
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         woke_q <= 1'b0;
      end else if (do_halt && cpu_wait_stop_i) begin
         woke_q <= 1'b1;
      end else if (!cpu_debug_active_i && !cpu_wait_stop_i && !halt_req_o) begin
         woke_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ws_q <= 1'b0;
      end else begin
         ws_q <= cpu_wait_stop_i || (woke_q && cpu_debug_active_i);
      end
   end

   // ----------------------------------------------------------------------
   // access failure flags, cleared by halt
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wsf_q <= 1'b0;
      end else begin
         wsf_q <= flag_next(wsf_q, cpu_mem_ws_conflict_i, do_halt);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dvf_q <= 1'b0;
      end else begin
         dvf_q <= flag_next(dvf_q, cpu_mem_slow_conflict_i, do_halt);
      end
   end

   // ----------------------------------------------------------------------
   // control bits and breakpoint register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bken_q <= 1'b0;
         fts_q <= 1'b0;
      end else if (do_write_control) begin
         bken_q <= cmd_wdata_i[dsbr_pkg::BREAKPOINT_ENABLE_BIT];
         fts_q <= cmd_wdata_i[dsbr_pkg::FORCE_TAG_SELECT_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bkpt_q <= dsbr_pkg::BKPT_RESET;
      end else if (do_bkpt_write) begin
         bkpt_q <= cmd_wdata_i;
      end
   end

   assign bk.enable = bken_q;
   assign bk.force_sel = fts_q;
   assign bk.match_addr = bkpt_q;

   dsbr_bkpt_cmp u_cmp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg(bk),
      .cpu_addr_i(cpu_addr_i),
      .cpu_addr_valid_i(cpu_addr_valid_i),
      .force_req_o(bkpt_force_o),
      .tag_req_o(bkpt_tag_o)
   );

   // ----------------------------------------------------------------------
   // command answers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_rdata_o <= 16'h0000;
         cmd_done_o <= 1'b0;
      end else begin
         cmd_done_o <= do_any;
         // a refused command decodes as none and answers zero
         if (cmd_eff == dsbr_pkg::DSBR_CMD_READ_STATUS) begin
            cmd_rdata_o <= {8'h00, status};
         end else if (cmd_eff == dsbr_pkg::DSBR_CMD_BKPT_READ) begin
            cmd_rdata_o <= bkpt_q;
         end else if (cmd_eff == dsbr_pkg::DSBR_CMD_FRST_READ) begin
            cmd_rdata_o <= {8'h00, dsbr_pkg::FORCED_RESET_READ};
         end else begin
            cmd_rdata_o <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------------
   // halt and forced reset
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_req_o <= 1'b0;
      end else begin
         halt_req_o <= do_halt;
      end
   end

   // user program writes (cpu_frst_write_i) are never looked at
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_reset_o <= 1'b0;
      end else begin
         sys_reset_o <= do_frst_write && cmd_wdata_i[dsbr_pkg::FORCED_RESET_BIT];
      end
   end
endmodule

// >>> test/dsbr_host.sv
// debug host model issuing serial commands to the block
`timescale 1ns/1ps
module dsbr_host (
   // clock
   input wire logic clk_i,
   // serial command port
   output dsbr_pkg::dsbr_cmd_t cmd_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rdata_i,
   input wire logic done_i
);
   initial cmd_o = dsbr_pkg::DSBR_CMD_NONE;
   initial wdata_o = 16'h0000;
   // one command, answer taken 1 ns after the edge that samples it
   task automatic cmd(input dsbr_pkg::dsbr_cmd_t k, input logic [15:0] d,
         output logic [15:0] rd, output logic dn);
      @(posedge clk_i);
      cmd_o <= k;
      wdata_o <= d;
      @(posedge clk_i);
      cmd_o <= dsbr_pkg::DSBR_CMD_NONE;
      wdata_o <= ~d;
      #1;
      rd = rdata_i;
      dn = done_i;
   endtask
endmodule

// >>> test/dsbr_top_sva.sv
// assertions on the ports of the debug status block
`timescale 1ns/1ps
module dsbr_top_sva (
   // clock and commands
   input wire logic clk_i,
   input wire logic rst_i,
   input wire dsbr_pkg::dsbr_cmd_t cmd_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] cmd_rdata_o,
   input wire logic cmd_done_o,
   // cpu side and requests
   input wire logic cpu_wait_stop_i,
   input wire logic cpu_addr_valid_i,
   input wire logic halt_req_o,
   input wire logic bkpt_force_o,
   input wire logic bkpt_tag_o,
   input wire logic sys_reset_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic halt = cmd_i == dsbr_pkg::DSBR_CMD_HALT;
   wire logic any = cmd_i != dsbr_pkg::DSBR_CMD_NONE;
   wire logic go = any && (!cpu_wait_stop_i || halt);
   wire logic frd = go && cmd_i == dsbr_pkg::DSBR_CMD_FRST_READ;
   wire logic fset = go && cmd_i == dsbr_pkg::DSBR_CMD_FRST_WRITE && cmd_wdata_i[0];
   property p_take; go |=> cmd_done_o; endproperty
   a_take: assert property (p_take) else $error("command not answered");
   property p_refuse; any && !go |=> !cmd_done_o && cmd_rdata_o == 16'h0000; endproperty
   a_refuse: assert property (p_refuse) else $error("wait stop command not refused");
   property p_cause; cmd_done_o |-> $past(go); endproperty
   a_cause: assert property (p_cause) else $error("done without command");
   property p_halt; halt |=> halt_req_o; endproperty
   a_halt: assert property (p_halt) else $error("halt not requested");
   property p_halt_src; halt_req_o |-> $past(halt); endproperty
   a_halt_src: assert property (p_halt_src) else $error("halt request without command");
   property p_frd; frd |=> cmd_rdata_o == 16'h0000; endproperty
   a_frd: assert property (p_frd) else $error("forced reset read not zero");
   property p_frst; fset |=> sys_reset_o; endproperty
   a_frst: assert property (p_frst) else $error("forced reset missing");
   property p_user; sys_reset_o |-> $past(fset); endproperty
   a_user: assert property (p_user) else $error("reset without serial write");
   property p_bkpt; bkpt_force_o || bkpt_tag_o |-> $past(cpu_addr_valid_i); endproperty
   a_bkpt: assert property (p_bkpt) else $error("breakpoint without bus cycle");
   property p_kind; !(bkpt_force_o && bkpt_tag_o); endproperty
   a_kind: assert property (p_kind) else $error("force and tag together");
endmodule

// >>> test/testbench.sv
// self-checking bench for the debug status and breakpoint block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   dsbr_pkg::dsbr_cmd_t cmd;
   logic [15:0] wd, rd, rdata, addr, ctl;
   logic done, dn, fw, ws, da, wsc, slc, av, hreq, bf, bt, sr;
   logic [15:0] exp_hit [3] = '{16'h0002, 16'h0001, 16'h0000};
   int n_mismatch = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   dsbr_host host (.clk_i(clk), .cmd_o(cmd), .wdata_o(wd), .rdata_i(rdata), .done_i(done));
   dsbr_top DUT (.clk_i(clk), .rst_i(rst), .cmd_i(cmd), .cmd_wdata_i(wd),
      .cmd_rdata_o(rdata), .cmd_done_o(done), .cpu_frst_write_i(fw),
      .cpu_frst_wdata_i(8'hff), .cpu_wait_stop_i(ws), .cpu_debug_active_i(da),
      .cpu_mem_ws_conflict_i(wsc), .cpu_mem_slow_conflict_i(slc), .cpu_addr_i(addr),
      .cpu_addr_valid_i(av), .halt_req_o(hreq), .bkpt_force_o(bf), .bkpt_tag_o(bt),
      .sys_reset_o(sr));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic c(input dsbr_pkg::dsbr_cmd_t k, input logic [15:0] d);
      host.cmd(k, d, rd, dn);
   endtask
   // one address bus cycle, requests seen one cycle later
   task automatic hit(input logic [15:0] a);
      @(posedge clk);
      addr <= a;
      av <= 1'b1;
      @(posedge clk);
      av <= 1'b0;
      #1;
   endtask
   initial begin
      {fw, ws, wsc, slc, av} = 5'h00;
      da = 1'b1;
      addr = 16'h0000;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      c(dsbr_pkg::DSBR_CMD_BKPT_READ, 16'h0000);
      chk(rd, 16'h0000);
      c(dsbr_pkg::DSBR_CMD_BKPT_WRITE, 16'hbeef);
      c(dsbr_pkg::DSBR_CMD_BKPT_READ, 16'h0000);
      chk(rd, 16'hbeef);
      @(posedge clk);
      da <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         ctl = 16'h0030 - 16'(i) * 16'h0010;
         c(dsbr_pkg::DSBR_CMD_WRITE_CONTROL, ctl);
         c(dsbr_pkg::DSBR_CMD_READ_STATUS, 16'h0000);
         chk(rd, ctl);
         hit(16'hbeef);
         chk({14'h0000, bf, bt}, exp_hit[i]);
         hit(16'hbeee);
         chk({14'h0000, bf, bt}, 16'h0000);
      end
      c(dsbr_pkg::DSBR_CMD_FRST_WRITE, 16'h00fe);
      c(dsbr_pkg::DSBR_CMD_FRST_READ, 16'h0000);
      chk(rd, 16'h0000);
      @(posedge clk);
      fw <= 1'b1;
      @(posedge clk);
      fw <= 1'b0;
      #1 chk({15'h0000, sr}, 16'h0000);
      c(dsbr_pkg::DSBR_CMD_FRST_WRITE, 16'h0001);
      chk({15'h0000, sr}, 16'h0001);
      @(posedge clk);
      ws <= 1'b1;
      c(dsbr_pkg::DSBR_CMD_BKPT_READ, 16'h0000);
      chk({15'h0000, dn}, 16'h0000);
      c(dsbr_pkg::DSBR_CMD_HALT, 16'h0000);
      chk({14'h0000, dn, hreq}, 16'h0003);
      @(posedge clk);
      ws <= 1'b0;
      da <= 1'b1;
      c(dsbr_pkg::DSBR_CMD_READ_STATUS, 16'h0000);
      chk(rd, 16'h0054);
      @(posedge clk);
      da <= 1'b0;
      wsc <= 1'b1;
      slc <= 1'b1;
      @(posedge clk);
      {wsc, slc} <= 2'b00;
      c(dsbr_pkg::DSBR_CMD_READ_STATUS, 16'h0000);
      chk(rd, 16'h0013);
      c(dsbr_pkg::DSBR_CMD_HALT, 16'h0000);
      @(posedge clk);
      da <= 1'b1;
      c(dsbr_pkg::DSBR_CMD_READ_STATUS, 16'h0000);
      chk(rd, 16'h0050);
      close_out;
   end
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
endmodule
bind dsbr_top dsbr_top_sva u_sva (.clk_i, .rst_i, .cmd_i, .cmd_wdata_i, .cmd_rdata_o,
   .cmd_done_o, .cpu_wait_stop_i, .cpu_addr_valid_i, .halt_req_o, .bkpt_force_o,
   .bkpt_tag_o, .sys_reset_o);
